// [shared/i2e_pkg.sv]
// Constants and carrier types for the transfer-end and own-address block
package i2e_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_CTRL2 = 8'h04;
  localparam logic [7:0] ADR_OWN_ADDRESS_ONE = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CT_LOW_W = 13;
  localparam int CT_START = 13;
  localparam int CT_STOP = 14;
  localparam int CT_NACK = 15;
  localparam int CT_CNT_LO = 16;
  localparam int CT_RELOAD = 24;
  localparam int CT_AUTOEND = 25;
  localparam int CT_PEC = 26;
  localparam int A1_LEN = 10;
  localparam int A1_EN = 15;
  localparam int CFG_PE = 0;
  localparam int CFG_SBC = 1;
  localparam int CFG_PECCHK = 2;
  localparam int ST_TC = 0;
  localparam int ST_TCR = 1;
  localparam int ST_HOLD = 2;
  localparam int ST_AMATCH = 3;
  localparam int ST_CNT_LO = 8;

  // ****************************************
  // Reset values and fixed codes
  // ****************************************
  localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
  localparam logic [15:0] OWN_ADDRESS_ONE_RST = 16'h0000;
  localparam logic [15:0] OWN_ADDRESS_ONE_MASK = 16'h87ff;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [4:0] HDR10 = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Events from the shift engine, same clock
  typedef struct packed {
    logic master_mode;
    logic start_sent;
    logic stop_sent;
    logic arb_lost;
    logic timeout;
    logic byte_done;
    logic pec_done;
    logic pec_ok;
    logic overrun;
  } i2e_evt_type;

  // Requests toward the shift engine
  typedef struct packed {
    logic start_req;
    logic stop_req;
    logic pec_req;
    logic last_nack;
    logic scl_hold;
  } i2e_req_type;

endpackage

// [design/i2e_addr_match.sv]
// Own-address-one comparator for 7-bit and 10-bit slave addressing
`timescale 1ns/1ps

module i2e_addr_match (
  input wire logic [7:0] byte_i,   // Received address byte
  input wire logic [9:0] addr_i,   // Own address one
  input wire logic len10_i,        // 10-bit addressing
  input wire logic en_i,           // Address enabled
  input wire logic second_i,       // Byte is 10-bit low part
  input wire logic seen10_i,       // Write header already matched
  output logic hit_o,              // Full enabled match
  output logic hdr_o               // 10-bit header matched
);

  logic a7;
  logic h10;
  logic l10;

  // 7-bit compare ignores bit 0 and the upper two bits
  // seven bit address
  assign a7 = ~len10_i & (byte_i[7:1] == addr_i[7:1]);
  assign h10 = len10_i & (byte_i[7:3] == i2e_pkg::HDR10) & (byte_i[2:1] == addr_i[9:8]);
  assign l10 = len10_i & (byte_i == addr_i[7:0]);

  // A disabled address never matches, so it is answered with NACK
  // enable gates match
  assign hit_o = en_i & (second_i ? l10 : (a7 | (h10 & byte_i[0] & seen10_i)));
  assign hdr_o = en_i & ~second_i & h10 & ~byte_i[0];

endmodule

// [design/i2e_xfer_end.sv]
// Transfer-end control and own-address-one slave front end
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps

// Operation
// - Stop request clears after stop sent or while disabled.
// - Writing zero to stop, NACK or PEC request does nothing.
// - NACK request clears after stop plus NACK, address match, or disable.
// - Slave answers next received byte NACK when request set, else ACK.
// - Master receiver NACKs the final byte before stop or restart.
// - Slave receiver NACKs on overrun regardless of NACK request.
// - With PEC checking, PEC byte answer follows check result.
// - Byte count sets transfer length; ignored in slave without byte control.
// - Byte count writable only while start request is clear.
// - Reload: after count set reload flag and hold SCL; else end.
// - Software end: after count set complete flag and hold SCL.
// - Automatic end: after count generate stop automatically.
// - End mode ignored in slave mode or with reload.
// - PEC request sends PEC byte; clears on done, stop, match, disable.
// - PEC request ignored with reload or slave without byte control.
// - Without SMBus support PEC request reads zero.
// - 7-bit own address uses bits 7:1 only.
// - 10-bit own address uses bits 9:0.
// - Length bit picks 7-bit when 0, 10-bit when 1.
// - Enabled own address ACKed, disabled one NACKed.
// - Own address register resets to zero.
// - Start request clears after start sent, arbitration loss, timeout, disable.
module i2e_xfer_end #(
  parameter int CNT_W = 8,             // Byte counter width
  parameter logic SMBUS_EN = 1'b1      // SMBus features present
) (
  input wire logic clk_i,              // System clock
  input wire logic rst_i,              // Synchronous reset
  input wire logic cyc_i,              // Wishbone cycle
  input wire logic stb_i,              // Wishbone strobe
  input wire logic we_i,               // Wishbone write
  input wire logic [7:0] adr_i,        // Wishbone byte address
  input wire logic [3:0] sel_i,        // Wishbone byte enables
  input wire logic [31:0] dat_i,       // Wishbone write data
  output logic [31:0] dat_o,           // Wishbone read data
  output logic ack_o,                  // Wishbone acknowledge
  input wire i2e_pkg::i2e_evt_type evt_i,   // Shift engine events
  output i2e_pkg::i2e_req_type req_o,       // Requests to engine
  input wire logic scl_i,              // SCL pin level
  input wire logic sda_i,              // SDA pin level
  output logic scl_o,                  // SCL drive value
  output logic scl_oe_n_o,             // SCL drive enable, low drives
  output logic sda_o,                  // SDA drive value
  output logic sda_oe_n_o              // SDA drive enable, low drives
);

  typedef enum logic [2:0] {SIDLE, SADDR, SADDR2, SDATA, SACK, SSKIP} i2e_st_type;

  // Byte-lane merge used by the control, address and status writes; config takes dat_i directly
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic ack_r;
  logic [31:0] rdat_r;
  logic [2:0] cfg_r;
  localparam int CT_LOW_W_L = i2e_pkg::CT_LOW_W;
  logic [CT_LOW_W_L-1:0] low_r;
  logic start_r, stop_r, nack_r, pec_r, reload_r, autoend_r;
  logic [CNT_W-1:0] cnt_r, rem_r, rem_nxt;
  logic [15:0] own_address_one_r;
  logic tc_r, tcr_r, hold_r, amatch_r, nack_sent_r, seen10_r;
  logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
  i2e_st_type st_r, after_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_drv_r;
  i2e_pkg::i2e_req_type req_r, req_nxt;

  // ****************************************
  // Bus decode
  // ****************************************
  logic wb_hit, wr_go, hit_cfg, hit_c2, hit_a1, hit_st, wr_c2, wr_st;
  logic [31:0] ctrl2_rd, stat_rd, rd_mux, wd2, wd_st, a1_wd;
  logic pe, sbc, pecchk, mst, slv;

  // Reads are answered one cycle after the request; writes land on the
  // edge where the master sees ack, so a write is taken exactly once
  assign wb_hit = cyc_i & stb_i;
  assign wr_go = wb_hit & we_i & ack_r;
  assign hit_cfg = adr_i[7:2] == i2e_pkg::ADR_CFG[7:2];
  assign hit_c2 = adr_i[7:2] == i2e_pkg::ADR_CTRL2[7:2];
  assign hit_a1 = adr_i[7:2] == i2e_pkg::ADR_OWN_ADDRESS_ONE[7:2];
  assign hit_st = adr_i[7:2] == i2e_pkg::ADR_STAT[7:2];
  assign wr_c2 = wr_go & hit_c2;
  assign wr_st = wr_go & hit_st;
  assign wd2 = merge(ctrl2_rd, dat_i, sel_i);
  assign wd_st = merge(32'h0000_0000, dat_i, sel_i);
  assign a1_wd = merge({16'h0000, own_address_one_r}, dat_i, sel_i);

  assign pe = cfg_r[i2e_pkg::CFG_PE];
  assign sbc = cfg_r[i2e_pkg::CFG_SBC];
  assign pecchk = cfg_r[i2e_pkg::CFG_PECCHK] & SMBUS_EN;
  assign mst = evt_i.master_mode;
  assign slv = ~evt_i.master_mode;

  // Read views; unmapped offsets read zero
  assign ctrl2_rd = {5'h00, pec_r, autoend_r, reload_r, cnt_r, nack_r, stop_r, start_r, low_r};
  assign stat_rd = {16'h0000, rem_r, 4'h0, amatch_r, hold_r, tcr_r, tc_r};
  assign rd_mux = hit_cfg ? {29'h0, cfg_r} :
                  hit_c2 ? ctrl2_rd :
                  hit_a1 ? {16'h0000, own_address_one_r} :
                  hit_st ? stat_rd : 32'h0000_0000;

  // Ack is a single pulse per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_hit & ~ack_r;
      rdat_r <= rd_mux;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = rdat_r;

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
    end
  end

  // Only the second stage and its delayed copy feed edge logic
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ****************************************
  // Address match and answer choice
  // ****************************************
  logic m_hit, m_hdr, byte_cmp, amatch_ev, data_cmp, ack_now, is_pec;
  logic pec_act, cnt_ev, last_ev;
  i2e_st_type after_nxt;

  i2e_addr_match u_match (
    .byte_i(sh_r),
    .addr_i(own_address_one_r[9:0]),
    .len10_i(own_address_one_r[i2e_pkg::A1_LEN]),
    .en_i(own_address_one_r[i2e_pkg::A1_EN]),
    .second_i(st_r == SADDR2),
    .seen10_i(seen10_r),
    .hit_o(m_hit),
    .hdr_o(m_hdr)
  );

  assign byte_cmp = scl_fall & (bit_r == i2e_pkg::BYTE_BITS) & ((st_r == SADDR) | (st_r == SADDR2) | (st_r == SDATA));
  assign amatch_ev = byte_cmp & m_hit;
  assign data_cmp = byte_cmp & (st_r == SDATA);

  assign pec_act = pec_r & ~reload_r & ~(slv & ~sbc);
  assign is_pec = pec_act & (rem_r == CNT_W'(1));

  // Overrun wins, then PEC check, then the software NACK request
  // overrun forces NACK
  assign ack_now = (st_r != SDATA) ? (m_hit | m_hdr) :
                   evt_i.overrun ? 1'b0 :
                   (pecchk & is_pec) ? evt_i.pec_ok : ~nack_r;

  // Read direction hands the bus to the data path, not followed here
  assign after_nxt = m_hdr ? SADDR2 :
                     (m_hit & ~sh_r[0] & (st_r != SDATA)) ? SDATA :
                     (st_r == SADDR2 & m_hit) ? SDATA :
                     (st_r == SDATA) ? SDATA : SSKIP;

  // ****************************************
  // Slave receive sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i | ~pe) begin
      st_r <= SIDLE;
      after_r <= SIDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_drv_r <= 1'b0;
      seen10_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= SIDLE;
      ack_drv_r <= 1'b0;
      seen10_r <= 1'b0;
    end else if (start_det) begin
      st_r <= SADDR;
      bit_r <= 4'h0;
      ack_drv_r <= 1'b0;
    end else begin
      case (st_r)
        SADDR, SADDR2, SDATA: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            bit_r <= bit_r + 4'h1;
          end else if (byte_cmp) begin
            ack_drv_r <= ack_now;
            after_r <= ack_now ? after_nxt : SSKIP;
            st_r <= SACK;
            bit_r <= 4'h0;
            if (m_hdr) begin
              seen10_r <= 1'b1;
            end
          end
        end
        SACK: begin
          if (scl_fall) begin
            ack_drv_r <= 1'b0;
            st_r <= after_r;
          end
        end
        SIDLE, SSKIP: begin
          bit_r <= 4'h0;
        end
        default: begin
          st_r <= SIDLE;
        end
      endcase
    end
  end

  // Open-drain pins: only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n_o = ~ack_drv_r;
  assign scl_oe_n_o = ~hold_r;

  // ****************************************
  // Byte counter and end of transfer
  // ****************************************
  logic start_set, cnt_ok, reload_go;
  logic [CNT_W-1:0] cnt_new;

  assign cnt_ev = (mst & evt_i.byte_done) | (slv & sbc & data_cmp);
  assign last_ev = cnt_ev & (rem_r == CNT_W'(1));
  assign cnt_ok = ~start_r;
  assign cnt_new = cnt_ok ? wd2[i2e_pkg::CT_CNT_LO +: CNT_W] : cnt_r;
  assign start_set = wr_c2 & wd2[i2e_pkg::CT_START];
  assign reload_go = wr_c2 & hold_r;

  always_comb begin
    rem_nxt = rem_r;
    if (start_set | reload_go | (amatch_ev & sbc)) begin
      rem_nxt = cnt_new;
    end else if (cnt_ev & (rem_r != CNT_W'(0))) begin
      rem_nxt = rem_r - CNT_W'(1);
    end
  end

  // ****************************************
  // Control, address and status registers
  // ****************************************
  logic stop_nxt, tc_set, tcr_set, hold_set, auto_stop, nack_set;

  assign tcr_set = last_ev & reload_r;
  // end mode only for master without reload
  assign tc_set = last_ev & ~reload_r & mst & ~autoend_r;
  assign auto_stop = last_ev & ~reload_r & mst & autoend_r;
  assign hold_set = tcr_set | tc_set;
  assign nack_set = wr_c2 & wd2[i2e_pkg::CT_NACK];

  // zero writes leave request bits alone
  assign stop_nxt = (wr_c2 & wd2[i2e_pkg::CT_STOP]) | auto_stop ? 1'b1 :
                    evt_i.stop_sent ? 1'b0 : stop_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= i2e_pkg::CFG_RST;
      own_address_one_r <= i2e_pkg::OWN_ADDRESS_ONE_RST;
      {pec_r, autoend_r, reload_r, cnt_r, nack_r, stop_r, start_r, low_r} <= i2e_pkg::CTRL2_RST[26:0];
      rem_r <= '0;
      {tc_r, tcr_r, hold_r, amatch_r, nack_sent_r} <= 5'h00;
    end else begin
      if (wr_go & hit_cfg) begin
        cfg_r <= dat_i[2:0];
      end
      if (wr_go & hit_a1) begin
        own_address_one_r <= a1_wd[15:0] & i2e_pkg::OWN_ADDRESS_ONE_MASK;
      end
      if (wr_c2) begin
        low_r <= wd2[CT_LOW_W_L-1:0];
        reload_r <= wd2[i2e_pkg::CT_RELOAD];
        autoend_r <= wd2[i2e_pkg::CT_AUTOEND];
        cnt_r <= cnt_new;
      end
      rem_r <= rem_nxt;
      // Disable clears every request bit and the held clock
      // disable clears stop
      if (~pe) begin
        {start_r, stop_r, nack_r, pec_r, hold_r} <= 5'h00;
      end else begin
        start_r <= start_set ? 1'b1 :
                   (evt_i.start_sent | evt_i.arb_lost | evt_i.timeout) ? 1'b0 : start_r;
        stop_r <= stop_nxt;
        nack_r <= nack_set ? 1'b1 :
                  (amatch_ev | (stop_det & nack_sent_r) | (evt_i.stop_sent & nack_sent_r)) ? 1'b0 : nack_r;
        pec_r <= (wr_c2 & wd2[i2e_pkg::CT_PEC] & SMBUS_EN) ? 1'b1 :
                 (evt_i.pec_done | stop_det | amatch_ev) ? 1'b0 : pec_r;
        hold_r <= hold_set ? 1'b1 : reload_go ? 1'b0 : hold_r;
      end
      // Flags: hardware set wins over write-one clear
      tc_r <= tc_set | (tc_r & ~(wr_st & wd_st[i2e_pkg::ST_TC]));
      tcr_r <= tcr_set | (tcr_r & ~(wr_st & wd_st[i2e_pkg::ST_TCR]));
      amatch_r <= amatch_ev | (amatch_r & ~(wr_st & wd_st[i2e_pkg::ST_AMATCH]));
      nack_sent_r <= (data_cmp & ~ack_now) | (nack_sent_r & ~stop_det & ~evt_i.stop_sent);
    end
  end

  // ****************************************
  // Requests toward the shift engine
  // ****************************************
  always_comb begin
    req_nxt.start_req = start_r;
    req_nxt.stop_req = stop_nxt & pe;
    req_nxt.pec_req = pec_act;
    req_nxt.last_nack = mst & ~reload_r & (rem_r == CNT_W'(1));
    req_nxt.scl_hold = hold_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end
  assign req_o = req_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_STOP_DIS: assert property (~pe |=> ~stop_r) else $error("stop request survives disable");
  AST_ZERO_WR: assert property (pe && stop_r && wr_c2 && !wd2[i2e_pkg::CT_STOP] && !evt_i.stop_sent
    |=> stop_r) else $error("zero write cleared stop request");
  AST_NACK_AM: assert property (pe && amatch_ev && !nack_set |=> !nack_r)
    else $error("NACK request not cleared on match");
  AST_OVR: assert property (pe && data_cmp && evt_i.overrun && !stop_det && !start_det
    |=> !ack_drv_r && st_r == SACK) else $error("overrun byte not NACKed");
  AST_CNT_LOCK: assert property (start_r && wr_c2 |=> $stable(cnt_r)) else $error("count changed during start");
  AST_RELOAD: assert property (pe && last_ev && reload_r |=> tcr_r && hold_r && !scl_oe_n_o)
    else $error("reload end did not hold SCL");
  AST_AUTO: assert property (pe && auto_stop && !evt_i.stop_sent |=> stop_r ##1 req_o.stop_req || !pe)
    else $error("automatic stop missing");
  AST_SLV_END: assert property (last_ev && slv && !tc_r && !(wr_st) |=> !tc_r)
    else $error("end mode acted in slave mode");
  AST_START: assert property (pe && start_r && evt_i.start_sent && !start_set |=> !start_r)
    else $error("start request not cleared");
  AST_A7: assert property (byte_cmp && st_r == SADDR && !own_address_one_r[i2e_pkg::A1_LEN] && !stop_det && !start_det
    && sh_r[7:1] != own_address_one_r[7:1] |=> !ack_drv_r) else $error("foreign 7-bit address ACKed");
  AST_DIS_A: assert property (byte_cmp && st_r == SADDR && !own_address_one_r[i2e_pkg::A1_EN] && !stop_det && !start_det
    |=> !ack_drv_r) else $error("disabled address ACKed");
  AST_PEC0: assert property (!SMBUS_EN |-> !pec_r) else $error("PEC request set without SMBus");

endmodule

// [verif/i2e_link_model.sv]
// Behavioural bus master on the serial link, paced by the system clock
`timescale 1ns/1ps

module i2e_link_model (
  input wire logic clk_i,   // System clock for pacing
  input wire logic sda_w_i, // Resolved SDA level
  output logic scl_o,       // SCL drive, 1 releases to pull-up
  output logic sda_o        // SDA drive, 1 releases to pull-up
);
  // ****************************************
  // Frame tasks, SCL half period 8 clocks
  // ****************************************
  // Idle bus: both lines released, SCL stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hp(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Start or restart: SDA falls while SCL high
  task automatic start_c;
    sda_o <= 1'b1;
    hp(4);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b0;
    hp(8);
    scl_o <= 1'b0;
    hp(4);
  endtask

  // Stop: SDA rises while SCL high
  task automatic stop_c;
    sda_o <= 1'b0;
    hp(4);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b1;
    hp(8);
  endtask

  // MSB first, then release SDA and sample the answer mid-high
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i];
      hp(4);
      scl_o <= 1'b1;
      hp(8);
      scl_o <= 1'b0;
      hp(4);
    end
    sda_o <= 1'b1;
    hp(4);
    scl_o <= 1'b1;
    hp(4);
    ack = ~sda_w_i;
    hp(4);
    scl_o <= 1'b0;
    hp(4);
  endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the transfer-end and own-address block
`timescale 1ns/1ps

module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} i2e_row_type;
  typedef struct packed {logic [15:0] ad; logic [7:0] b0; logic [7:0] b1; logic k0; logic k1;} i2e_srow_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  i2e_pkg::i2e_evt_type evt = '0;
  i2e_pkg::i2e_req_type req;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, a;
  logic [31:0] q;
  int fails = 0;
  int checks_done = 0;
  // Open-drain wires: any low driver wins over the pull-up
  wire scl_w = m_scl & (scl_oe_n | scl_o);
  wire sda_w = m_sda & (sda_oe_n | sda_o);
  i2e_row_type rows [7] = '{
    '{i2e_pkg::ADR_OWN_ADDRESS_ONE, 32'hffff_ffff, 32'h0000_87ff}, '{i2e_pkg::ADR_OWN_ADDRESS_ONE, 32'h0, 32'h0},
    '{8'h1c, 32'hffff_ffff, 32'h0}, '{i2e_pkg::ADR_CTRL2, 32'h03ab_1fff, 32'h03ab_1fff},
    '{i2e_pkg::ADR_CTRL2, 32'h0000_c000, 32'h0000_c000}, '{i2e_pkg::ADR_CTRL2, 32'h0, 32'h0000_c000},
    '{i2e_pkg::ADR_CTRL2, 32'h0400_0000, 32'h0400_c000}};
  i2e_srow_type srows [4] = '{'{16'h0054, 8'h54, 8'h11, 1'b0, 1'b0}, '{16'h8355, 8'h54, 8'h11, 1'b1, 1'b1},
    '{16'h87a5, 8'hf6, 8'ha5, 1'b1, 1'b1}, '{16'h87a5, 8'hf6, 8'ha4, 1'b1, 1'b0}};
  logic [31:0] ctl [3] = '{32'h0001_2000, 32'h0101_2000, 32'h0201_2000};
  logic [31:0] stx [3] = '{32'h5, 32'h6, 32'h0};

  always #5 clk_i = ~clk_i;

  i2e_xfer_end dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .evt_i(evt), .req_o(req), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
  i2e_link_model m (.clk_i(clk_i), .sda_w_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, ad, d, 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i);
    evt[b] <= 1'b1;
    @(posedge clk_i);
    evt[b] <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    chk("req in reset", 32'(req), 32'h0);
    chk("scl oe in reset", 32'(scl_oe_n), 32'h1);
    rst_i <= 1'b0;
    wb(i2e_pkg::ADR_OWN_ADDRESS_ONE, 1'b0, 32'h0);
    chk("own_address_one reset", q, 32'h0);
    wb(i2e_pkg::ADR_CFG, 1'b1, 32'h1);
    // Register rows: write, read back
    foreach (rows[i]) begin
      wb(rows[i].a, 1'b1, rows[i].d);
      wb(rows[i].a, 1'b0, 32'h0);
      chk("reg row", q, rows[i].e);
    end
    // Disable clears the stop, NACK and PEC request bits
    wb(i2e_pkg::ADR_CFG, 1'b1, 32'h0);
    wb(i2e_pkg::ADR_CTRL2, 1'b0, 32'h0);
    chk("ctrl2 off", q, 32'h0);
    wb(i2e_pkg::ADR_CFG, 1'b1, 32'h1);
    wb(i2e_pkg::ADR_CTRL2, 1'b1, 32'h0000_4000);
    pulse(6);
    wb(i2e_pkg::ADR_CTRL2, 1'b0, 32'h0);
    chk("stop clear", q, 32'h0);
    evt.master_mode <= 1'b1;
    // Software end, reload, automatic end
    for (int k = 0; k < 3; k++) begin
      wb(i2e_pkg::ADR_CTRL2, 1'b1, ctl[k]);
      wb(i2e_pkg::ADR_CTRL2, 1'b1, ctl[k] | 32'h00fe_0000);
      wb(i2e_pkg::ADR_CTRL2, 1'b0, 32'h0);
      chk("count lock", q, ctl[k]);
      chk("start req", 32'(req.start_req), 32'h1);
      chk("last nack", 32'(req.last_nack), 32'(k != 1));
      pulse(7);
      wb(i2e_pkg::ADR_CTRL2, 1'b0, 32'h0);
      chk("start clear", q, ctl[k] & 32'hffff_dfff);
      pulse(3);
      repeat (4) @(posedge clk_i);
      chk("auto stop", 32'(req.stop_req), 32'(k == 2));
      chk("scl held", 32'(scl_oe_n), 32'(k == 2));
      wb(i2e_pkg::ADR_STAT, 1'b0, 32'h0);
      chk("end flags", q & 32'h7, stx[k]);
      wb(i2e_pkg::ADR_CTRL2, 1'b1, 32'h0000_4000);
      repeat (3) @(posedge clk_i);
      chk("scl released", 32'(scl_oe_n), 32'h1);
      pulse(6);
      wb(i2e_pkg::ADR_STAT, 1'b1, 32'hb);
    end
    // PEC request in master mode with zero count and no start, cleared when the byte is done
    wb(i2e_pkg::ADR_CTRL2, 1'b1, 32'h0400_0000);
    repeat (2) @(posedge clk_i);
    chk("pec req", 32'(req.pec_req), 32'h1);
    pulse(2);
    repeat (2) @(posedge clk_i);
    chk("pec done", 32'(req.pec_req), 32'h0);
    evt.master_mode <= 1'b0;
    // Slave address rows: address byte, then one more byte
    foreach (srows[i]) begin
      wb(i2e_pkg::ADR_OWN_ADDRESS_ONE, 1'b1, {16'h0, srows[i].ad});
      m.start_c();
      m.send(srows[i].b0, a);
      chk("addr ack", 32'(a), 32'(srows[i].k0));
      m.send(srows[i].b1, a);
      chk("second ack", 32'(a), 32'(srows[i].k1));
      m.stop_c();
    end
    // NACK request, match clearing it, overrun
    wb(i2e_pkg::ADR_OWN_ADDRESS_ONE, 1'b1, 32'h0000_8054);
    wb(i2e_pkg::ADR_CTRL2, 1'b1, 32'h0000_8000);
    m.start_c();
    m.send(8'h54, a);
    chk("match ack", 32'(a), 32'h1);
    wb(i2e_pkg::ADR_CTRL2, 1'b0, 32'h0);
    chk("nack clear", q, 32'h0);
    m.send(8'h11, a);
    chk("data ack", 32'(a), 32'h1);
    evt.overrun <= 1'b1;
    m.send(8'h22, a);
    chk("overrun nack", 32'(a), 32'h0);
    evt.overrun <= 1'b0;
    wb(i2e_pkg::ADR_CTRL2, 1'b1, 32'h0000_8000);
    m.send(8'h33, a);
    chk("nack req", 32'(a), 32'h0);
    m.stop_c();
    complete_run();
  end
endmodule
